// ===== rtl/bebs_pkg.sv
// Package for the bus event breakpoint sequencer: widths, map, field positions, carriers
package bebs_pkg;

  // ********************************************************
  // Widths and sizes
  // ********************************************************
  localparam int BEBS_ADDR_W  = 24;   // Emulated bus address width
  localparam int BEBS_DATA_W  = 8;    // Emulated bus data width
  localparam int BEBS_TRIG_N  = 9;    // Input trigger lines
  localparam int BEBS_OTRIG_N = 2;    // Output trigger lines
  localparam int BEBS_LEVELS  = 4;    // Sequencer levels
  localparam int BEBS_EVENTS  = 16;   // Four events per level
  localparam int BEBS_TERMS   = 8;    // Two terms per level
  localparam int BEBS_CNT_W   = 16;   // Occurrence counter width
  localparam int BEBS_TERM_W  = 17;   // Term word width
  localparam int BEBS_APB_AW  = 12;   // APB address width

  // ********************************************************
  // Register map (byte addresses)
  // ********************************************************
  localparam logic [11:0] BEBS_CTRL_OFF   = 12'h000;
  localparam logic [11:0] BEBS_STATUS_OFF = 12'h004;
  localparam logic [11:0] BEBS_TERM_OFF   = 12'h040;  // 8 words, index level*2+term
  localparam logic [11:0] BEBS_LIMIT_OFF  = 12'h060;  // 8 words
  localparam logic [11:0] BEBS_COUNT_OFF  = 12'h080;  // 8 words, read only
  localparam logic [11:0] BEBS_EVENT_OFF  = 12'h100;  // 16 events x 4 words
  localparam logic [1:0]  BEBS_EV_LO      = 2'h0;     // Address / range low
  localparam logic [1:0]  BEBS_EV_HI      = 2'h1;     // Range high
  localparam logic [1:0]  BEBS_EV_DM      = 2'h2;     // [15:8] mask, [7:0] pattern
  localparam logic [1:0]  BEBS_EV_CTL     = 2'h3;     // Qualifier enables

  // ********************************************************
  // Control register bits
  // ********************************************************
  localparam int BEBS_C_ARM    = 0;
  localparam int BEBS_C_TRSTRT = 1;   // Start with recording on
  localparam int BEBS_C_TOG0   = 2;   // Output trigger 0 toggles, else pulses
  localparam int BEBS_C_TOG1   = 3;
  localparam int BEBS_CTRL_W   = 4;

  // ********************************************************
  // Event qualifier bits
  // ********************************************************
  localparam int BEBS_E_ADDR  = 0;
  localparam int BEBS_E_RANGE = 1;
  localparam int BEBS_E_DATA  = 2;
  localparam int BEBS_E_DIR   = 3;    // 2 bits: 0 any, 1 read, 2 write
  localparam int BEBS_E_FETCH = 5;
  localparam int BEBS_E_DMA   = 6;
  localparam int BEBS_E_IRQ   = 7;
  localparam int BEBS_E_STACK = 8;
  localparam int BEBS_E_TRIG  = 9;
  localparam int BEBS_E_TALL  = 10;
  localparam int BEBS_E_TSEL  = 11;   // 4 bits
  localparam int BEBS_E_TFULL = 15;

  // ********************************************************
  // Term word bits
  // ********************************************************
  localparam int BEBS_T_FSEL = 0;     // 2 bits: 0 disabled, 1 event, 2 not event
  localparam int BEBS_T_OP   = 2;     // 3 bits
  localparam int BEBS_T_INV2 = 5;
  localparam int BEBS_T_CNT  = 6;
  localparam int BEBS_T_MODE = 7;     // 0 at least, 1 below
  localparam int BEBS_T_HALT = 8;
  localparam int BEBS_T_TRG0 = 9;
  localparam int BEBS_T_TRG1 = 10;
  localparam int BEBS_T_TRON = 11;
  localparam int BEBS_T_TROF = 12;
  localparam int BEBS_T_SNAP = 13;
  localparam int BEBS_T_GOTO = 14;
  localparam int BEBS_T_LVL  = 15;    // 2 bits

  typedef enum logic [2:0] {
    BEBS_OP_NONE = 3'b000,
    BEBS_OP_AND  = 3'b001,
    BEBS_OP_OR   = 3'b010,
    BEBS_OP_NAND = 3'b011,
    BEBS_OP_NOR  = 3'b100,
    BEBS_OP_EQV  = 3'b101,  // equivalence_operator
    BEBS_OP_XOR  = 3'b110
  } bebs_op_t;

  // ********************************************************
  // Carriers
  // ********************************************************
  typedef struct packed {
    logic                   valid;  // One observed bus cycle
    logic [BEBS_ADDR_W-1:0] addr;
    logic [BEBS_DATA_W-1:0] data;
    logic                   write;
    logic                   fetch;
    logic                   dma;
    logic                   irq;
    logic                   stack;
  } bebs_bus_t;

  typedef struct packed {
    logic [BEBS_ADDR_W-1:0] addr;
    logic [BEBS_DATA_W-1:0] data;
    logic                   write;
    logic                   fetch;
    logic                   dma;
    logic                   irq;
    logic                   stack;
    logic                   snapshot;
  } bebs_rec_t;

endpackage

// ===== rtl/bebs_sequencer.sv
// Bus event machine: four-level event sequencer with APB configuration
//
// What this block does
// - Four programmable levels; the satisfied term of the active level fires its actions.
// - Event matches one address or any address within a low/high range.
// - Event matches bus data against a pattern on mask-enabled bits only.
// - Event qualifies on direction: read only, write only, or either.
// - Event qualifies on opcode fetch, DMA, interrupt or stack cycle.
// - Event depends on nine input triggers, one selected line or all.
// - Any set of qualifiers, trace-full included, combines; all must match.
// - A term may request a halt, signalled to execution control.
// - A term may drive a waveform on either or both output triggers.
// - A term may switch recording on or off; non-snapshot cycles stored only while on.
// - A term may store one snapshot record even with recording off.
// - A term may move to another level, evaluated from then on.
// - Several actions of one term happen on the same bus cycle.
// - Only observes the bus; never stalls or alters the emulated core.
// - Halt has latency; the core may run a few more instructions.
// - Each level holds four events, two per term.
// - Alternative term applies only when the primary term is not met.
// - Two events join by AND, OR, NAND, NOR, equivalence or XOR.
// - Each operand invertible; first event may go through a counter.
// - At-least mode true once count reaches the limit or more.
// - Below mode true while count is under the limit.
// - Two counters per level, on each term's first event only.
// - A term whose first event is disabled never fires.
`timescale 1ns/1ps

module bebs_sequencer (
  input  wire logic                                 CLK_IN,
  input  wire logic                                 RST_IN,
  // APB slave
  input  wire logic                                 PSEL_IN,
  input  wire logic                                 PENABLE_IN,
  input  wire logic                                 PWRITE_IN,
  input  wire logic [bebs_pkg::BEBS_APB_AW-1:0]     PADDR_IN,
  input  wire logic [31:0]                          PWDATA_IN,
  output logic      [31:0]                          PRDATA_OUT,
  output logic                                      PREADY_OUT,
  output logic                                      PSLVERR_OUT,
  // Observed bus and status
  input  wire bebs_pkg::bebs_bus_t                  BUS_IN,
  input  wire logic                                 TRACE_FULL_IN,
  input  wire logic [bebs_pkg::BEBS_TRIG_N-1:0]     TRIG_IN,
  // Actions
  output logic                                      HALT_REQ_OUT,
  output logic      [bebs_pkg::BEBS_OTRIG_N-1:0]    TRIG_OUT,
  output logic                                      TRACE_WE_OUT,
  output bebs_pkg::bebs_rec_t                       TRACE_REC_OUT,
  output logic                                      ARMED_OUT
);
  import bebs_pkg::*;

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic [BEBS_EVENTS-1:0][BEBS_ADDR_W-1:0] ev_lo;
    logic [BEBS_EVENTS-1:0][BEBS_ADDR_W-1:0] ev_hi;
    logic [BEBS_EVENTS-1:0][15:0]            ev_dm;
    logic [BEBS_EVENTS-1:0][15:0]            ev_ctl;
    logic [BEBS_TERMS-1:0][BEBS_TERM_W-1:0]  term;
    logic [BEBS_TERMS-1:0][BEBS_CNT_W-1:0]   limit;
    logic [BEBS_TERMS-1:0][BEBS_CNT_W-1:0]   cnt;
    logic [BEBS_CTRL_W-1:0]                  ctrl;
    logic                                    armed;
    logic [1:0]                              level;
    logic                                    trace_on;
    logic                                    halt_seen;
    logic                                    halt;
    logic [BEBS_OTRIG_N-1:0]                 trig;
    logic                                    trace_we;
    bebs_rec_t                               rec;
    logic                                    pready;
    logic                                    pslverr;
    logic [31:0]                             prdata;
    logic [BEBS_TRIG_N-1:0]                  trig_s1;
    logic [BEBS_TRIG_N-1:0]                  trig_s2;
  } bebs_state_t;

  bebs_state_t s;
  bebs_state_t next_s;

  // ********************************************************
  // Functions
  // ********************************************************
  // One event comparator; a qualifier left off matches anything
  // Line selects past the last trigger never match, so a stray
  // select cannot alias onto a real line
  function automatic logic ev_match(input logic [BEBS_ADDR_W-1:0] lo,
                                    input logic [BEBS_ADDR_W-1:0] hi,
                                    input logic [15:0]            dm,
                                    input logic [15:0]            ctl,
                                    input bebs_bus_t              b,
                                    input logic [BEBS_TRIG_N-1:0] trg,
                                    input logic                   tfull);
    logic m;
    logic [3:0] tsel;
    m    = 1'b1;
    tsel = ctl[BEBS_E_TSEL+:4];
    if (ctl[BEBS_E_ADDR]) begin
      if (ctl[BEBS_E_RANGE]) begin
        m = m & (b.addr >= lo) & (b.addr <= hi);
      end else begin
        m = m & (b.addr == lo);
      end
    end
    if (ctl[BEBS_E_DATA]) begin
      m = m & (((b.data ^ dm[7:0]) & dm[15:8]) == 8'h00);
    end
    case (ctl[BEBS_E_DIR+:2])
      2'h1:    m = m & ~b.write;
      2'h2:    m = m & b.write;
      default: m = m;
    endcase
    if (ctl[BEBS_E_FETCH]) m = m & b.fetch;
    if (ctl[BEBS_E_DMA])   m = m & b.dma;
    if (ctl[BEBS_E_IRQ])   m = m & b.irq;
    if (ctl[BEBS_E_STACK]) m = m & b.stack;
    if (ctl[BEBS_E_TRIG]) begin
      if (ctl[BEBS_E_TALL]) begin
        m = m & (&trg);
      end else if (tsel < 4'(BEBS_TRIG_N)) begin
        m = m & trg[tsel];
      end else begin
        m = 1'b0;
      end
    end
    if (ctl[BEBS_E_TFULL]) m = m & tfull;
    return m;
  endfunction

  // Saturating occurrence count including the present cycle
  // Saturation keeps a below-mode term false once the limit is met
  function automatic logic [BEBS_CNT_W-1:0] cnt_step(input logic [BEBS_CNT_W-1:0] c,
                                                     input logic                  hit);
    return (hit && (c != {BEBS_CNT_W{1'b1}})) ? c + 1'b1 : c;
  endfunction

  // One IF/ELSE IF term from its two event matches and its counter value
  // Counter result replaces the raw first match before inversion
  function automatic logic term_eval(input logic [BEBS_TERM_W-1:0] t,
                                     input logic                   m1,
                                     input logic                   m2,
                                     input logic [BEBS_CNT_W-1:0]  c,
                                     input logic [BEBS_CNT_W-1:0]  lim);
    logic a;
    logic b;
    logic r;
    a = m1;
    if (t[BEBS_T_CNT]) begin
      a = t[BEBS_T_MODE] ? (c < lim)
                         : (c >= lim);
    end
    a = a ^ (t[BEBS_T_FSEL+:2] == 2'h2);
    b = m2 ^ t[BEBS_T_INV2];
    case (bebs_op_t'(t[BEBS_T_OP+:3]))
      BEBS_OP_NONE: r = a;
      BEBS_OP_AND:  r = a & b;
      BEBS_OP_OR:   r = a | b;
      BEBS_OP_NAND: r = ~(a & b);
      BEBS_OP_NOR:  r = ~(a | b);
      BEBS_OP_EQV:  r = ~(a ^ b);
      BEBS_OP_XOR:  r = a ^ b;
      default:      r = 1'b0;
    endcase
    // Disabled first event leaves the term void
    if ((t[BEBS_T_FSEL+:2] != 2'h1) && (t[BEBS_T_FSEL+:2] != 2'h2)) begin
      r = 1'b0;
    end
    return r;
  endfunction

  // ********************************************************
  // Next-state logic
  // ********************************************************
  always_comb begin
    logic [3:0]             ev_base;
    logic [2:0]             t_base;
    logic [3:0]             m;
    logic [BEBS_CNT_W-1:0]  c_p;
    logic [BEBS_CNT_W-1:0]  c_a;
    logic                   fire_p;
    logic                   fire_a;
    logic                   fire;
    logic [BEBS_TERM_W-1:0] act;
    logic                   hit;
    logic [31:0]            rd;
    logic [11:0]            a;
    logic [3:0]             ei;
    logic [2:0]             ti;
    logic                   wr;
    ev_base = 4'h0;
    t_base  = 3'h0;
    m       = 4'h0;
    c_p     = '0;
    c_a     = '0;
    fire_p  = 1'b0;
    fire_a  = 1'b0;
    fire    = 1'b0;
    act     = '0;
    hit     = 1'b0;
    rd      = 32'h0000_0000;
    a       = PADDR_IN;
    ei      = a[7:4];
    ti      = a[4:2];
    wr      = 1'b0;
    next_s  = s;

    // Pin synchroniser; only the second stage feeds the comparators
    // Costs two cycles of latency on every trigger line
    next_s.trig_s1 = TRIG_IN;
    next_s.trig_s2 = s.trig_s1;

    // Pulses last one cycle; toggle-mode triggers hold their level
    next_s.halt     = 1'b0;
    next_s.trace_we = 1'b0;
    next_s.trig[0]  = s.ctrl[BEBS_C_TOG0] ? s.trig[0] : 1'b0;
    next_s.trig[1]  = s.ctrl[BEBS_C_TOG1] ? s.trig[1] : 1'b0;

    // Level and counters move here and on arming; the APB write
    // path below wins when both touch them in one cycle
    // Sequencer: one evaluation per observed bus cycle, output only
    if (s.armed && BUS_IN.valid) begin
      ev_base = {s.level, 2'b00};
      t_base  = {s.level, 1'b0};
      for (int k = 0; k < 4; k++) begin
        m[k] = ev_match(s.ev_lo[ev_base + 4'(k)], s.ev_hi[ev_base + 4'(k)],
                        s.ev_dm[ev_base + 4'(k)], s.ev_ctl[ev_base + 4'(k)],
                        BUS_IN, s.trig_s2, TRACE_FULL_IN);
      end
      c_p = cnt_step(s.cnt[t_base], m[0]);
      c_a = cnt_step(s.cnt[t_base + 3'h1], m[2]);
      next_s.cnt[t_base]        = c_p;
      next_s.cnt[t_base + 3'h1] = c_a;
      fire_p = term_eval(s.term[t_base], m[0], m[1], c_p, s.limit[t_base]);
      fire_a = term_eval(s.term[t_base + 3'h1], m[2], m[3], c_a, s.limit[t_base + 3'h1]);
      // Alternative only considered when the primary term fails
      if (fire_p) begin
        act  = s.term[t_base];
        fire = 1'b1;
      end else if (fire_a) begin
        act  = s.term[t_base + 3'h1];
        fire = 1'b1;
      end
      // Record the cycle while recording is on, or as a snapshot
      next_s.trace_we = s.trace_on | (fire & act[BEBS_T_SNAP]);
      next_s.rec      = '{addr: BUS_IN.addr, data: BUS_IN.data, write: BUS_IN.write,
                          fetch: BUS_IN.fetch, dma: BUS_IN.dma, irq: BUS_IN.irq,
                          stack: BUS_IN.stack, snapshot: fire & act[BEBS_T_SNAP]};
      // All selected actions are applied together, except that recording on overrides recording off
      if (fire) begin
        if (act[BEBS_T_HALT]) begin
          next_s.halt = 1'b1;
        end
        if (act[BEBS_T_TRG0]) begin
          next_s.trig[0] = s.ctrl[BEBS_C_TOG0] ? ~s.trig[0] : 1'b1;
        end
        if (act[BEBS_T_TRG1]) begin
          next_s.trig[1] = s.ctrl[BEBS_C_TOG1] ? ~s.trig[1] : 1'b1;
        end
        if (act[BEBS_T_TRON]) begin
          next_s.trace_on = 1'b1;
        end else if (act[BEBS_T_TROF]) begin
          next_s.trace_on = 1'b0;
        end
        if (act[BEBS_T_GOTO]) begin
          next_s.level = act[BEBS_T_LVL+:2];
        end
      end
    end

    // APB read decode, answered in the setup cycle's following edge
    if (a[1:0] == 2'b00) begin
      if (a == BEBS_CTRL_OFF) begin
        hit = 1'b1;
        rd  = 32'(s.ctrl);
      end else if (a == BEBS_STATUS_OFF) begin
        hit = 1'b1;
        rd  = {17'h0_0000, s.trig_s2, TRACE_FULL_IN, s.halt_seen, s.trace_on, s.level, s.armed};
      end else if (a[11:5] == BEBS_TERM_OFF[11:5]) begin
        hit = 1'b1;
        rd  = 32'(s.term[ti]);
      end else if (a[11:5] == BEBS_LIMIT_OFF[11:5]) begin
        hit = 1'b1;
        rd  = 32'(s.limit[ti]);
      end else if (a[11:5] == BEBS_COUNT_OFF[11:5]) begin
        hit = 1'b1;
        rd  = 32'(s.cnt[ti]);
      end else if (a[11:8] == BEBS_EVENT_OFF[11:8]) begin
        hit = 1'b1;
        case (a[3:2])
          BEBS_EV_LO:  rd = 32'(s.ev_lo[ei]);
          BEBS_EV_HI:  rd = 32'(s.ev_hi[ei]);
          BEBS_EV_DM:  rd = 32'(s.ev_dm[ei]);
          default:     rd = 32'(s.ev_ctl[ei]);
        endcase
      end
    end

    // No wait state: ready rises in the access phase only
    // Read data and error stand only beside ready, so a late
    // sampler on the bus never sees a stale word
    next_s.pready = PSEL_IN & ~PENABLE_IN & ~s.pready;
    if (PSEL_IN && !PENABLE_IN) begin
      next_s.prdata  = PWRITE_IN ? 32'h0000_0000 : rd;
      next_s.pslverr = ~hit;
    end else begin
      next_s.prdata  = 32'h0000_0000;
      next_s.pslverr = 1'b0;
    end

    // APB write at the completing edge; read-only words ignore it
    wr = PSEL_IN & PENABLE_IN & s.pready & PWRITE_IN & hit;
    if (wr) begin
      if (a == BEBS_CTRL_OFF) begin
        next_s.ctrl = PWDATA_IN[BEBS_CTRL_W-1:0];
        if (PWDATA_IN[BEBS_C_ARM] && !s.armed) begin
          next_s.armed     = 1'b1;
          next_s.level     = 2'h0;
          next_s.cnt       = '0;
          next_s.trace_on  = PWDATA_IN[BEBS_C_TRSTRT];
          next_s.halt_seen = 1'b0;
          next_s.trig      = '0;
        end else if (!PWDATA_IN[BEBS_C_ARM]) begin
          next_s.armed    = 1'b0;
          next_s.trace_on = 1'b0;
        end
      end else if (a[11:5] == BEBS_TERM_OFF[11:5]) begin
        next_s.term[ti] = PWDATA_IN[BEBS_TERM_W-1:0];
      end else if (a[11:5] == BEBS_LIMIT_OFF[11:5]) begin
        next_s.limit[ti] = PWDATA_IN[BEBS_CNT_W-1:0];
      end else if (a[11:8] == BEBS_EVENT_OFF[11:8]) begin
        case (a[3:2])
          BEBS_EV_LO:  next_s.ev_lo[ei]  = PWDATA_IN[BEBS_ADDR_W-1:0];
          BEBS_EV_HI:  next_s.ev_hi[ei]  = PWDATA_IN[BEBS_ADDR_W-1:0];
          BEBS_EV_DM:  next_s.ev_dm[ei]  = PWDATA_IN[15:0];
          default:     next_s.ev_ctl[ei] = PWDATA_IN[15:0];
        endcase
      end
    end

    // Sticky halt flag: a halt in the arming cycle is not lost
    // Cleared only by arming; the set wins over the clear
    if (next_s.halt) begin
      next_s.halt_seen = 1'b1;
    end
  end

  // ********************************************************
  // State register
  // ********************************************************
  // Reset disables every term, so nothing fires until software
  // programs a level and arms the sequencer
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  // No bus input reaches a pin combinationally; the price is
  // one cycle of action latency after the matching bus cycle
  assign PRDATA_OUT    = s.prdata;
  assign PREADY_OUT    = s.pready;
  assign PSLVERR_OUT   = s.pslverr;
  assign HALT_REQ_OUT  = s.halt;
  assign TRIG_OUT      = s.trig;
  assign TRACE_WE_OUT  = s.trace_we;
  assign TRACE_REC_OUT = s.rec;
  assign ARMED_OUT     = s.armed;

endmodule // bebs_sequencer

// ===== tb/bebs_chk.sv
// Port checker for the event sequencer
`timescale 1ns/1ps
module bebs_chk (
  input wire logic                CLK_IN,
  input wire logic                RST_IN,
  input wire logic                PSEL_IN,
  input wire logic                PENABLE_IN,
  input wire logic                PREADY_OUT,
  input wire logic                PSLVERR_OUT,
  input wire logic [31:0]         PRDATA_OUT,
  input wire bebs_pkg::bebs_bus_t BUS_IN,
  input wire logic                HALT_REQ_OUT,
  input wire logic [1:0]          TRIG_OUT,
  input wire logic                TRACE_WE_OUT,
  input wire bebs_pkg::bebs_rec_t TRACE_REC_OUT,
  input wire logic                ARMED_OUT
);
  import bebs_pkg::*;
  // ****
  // Properties
  // ****
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  property p_halt; HALT_REQ_OUT |-> $past(BUS_IN.valid && ARMED_OUT); endproperty
  a_halt: assert property (p_halt) else $error("halt without cause");
  property p_we; TRACE_WE_OUT |-> $past(BUS_IN.valid && ARMED_OUT); endproperty
  a_we: assert property (p_we) else $error("trace write without cause");
  property p_rec;
    TRACE_WE_OUT |-> TRACE_REC_OUT.addr == $past(BUS_IN.addr) && TRACE_REC_OUT.data == $past(BUS_IN.data);
  endproperty
  a_rec: assert property (p_rec) else $error("record differs from bus");
  property p_trig; (|(TRIG_OUT & ~$past(TRIG_OUT))) |-> $past(BUS_IN.valid && ARMED_OUT); endproperty
  a_trig: assert property (p_trig) else $error("trigger without cause");
  property p_rdy; PSEL_IN && !PENABLE_IN |=> PREADY_OUT; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_rdy1; PREADY_OUT |=> !PREADY_OUT; endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready too long");
  property p_err; PSLVERR_OUT |-> PREADY_OUT; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_idle; !PREADY_OUT |-> PRDATA_OUT == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data while idle");
  c_halt: cover property (HALT_REQ_OUT);
  c_snap: cover property (TRACE_WE_OUT && TRACE_REC_OUT.snapshot);
  c_err: cover property (PSLVERR_OUT);
endmodule // bebs_chk

bind bebs_sequencer bebs_chk u_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .PRDATA_OUT(PRDATA_OUT), .BUS_IN(BUS_IN),
  .HALT_REQ_OUT(HALT_REQ_OUT), .TRIG_OUT(TRIG_OUT), .TRACE_WE_OUT(TRACE_WE_OUT),
  .TRACE_REC_OUT(TRACE_REC_OUT), .ARMED_OUT(ARMED_OUT));

// ===== tb/bebs_core.sv
// Emulated core model: issues bus cycles, stops after a halt
`timescale 1ns/1ps
module bebs_core (
  input  wire logic           clk_in,
  input  wire logic           rst_in,
  input  wire logic           go_in,
  input  wire logic [23:0]    addr_in,
  input  wire logic           halt_in,
  output bebs_pkg::bebs_bus_t bus_out,
  output logic                halted_out
);
  import bebs_pkg::*;
  // Idle address and data lines show the inverse of their last value, never a stale copy
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_out    <= '0;
      halted_out <= 1'b0;
    end else begin
      bus_out.valid <= go_in && !halted_out;
      bus_out.addr  <= go_in ? addr_in : ~bus_out.addr;
      bus_out.data  <= go_in ? addr_in[7:0] : ~bus_out.data;
      halted_out    <= halted_out || halt_in; // No more cycles once stopped
    end
  end
endmodule // bebs_core

// ===== tb/tb_bus_event_breakpoint_sequencer.sv
// Self-checking bench for the event sequencer
`timescale 1ns/1ps
module tb_bus_event_breakpoint_sequencer;
  import bebs_pkg::*;
  logic        clk, rst, psel, pen, pwr, go, er, pready, pslverr, halt, twe, armed, tfull;
  logic [1:0]  tout;
  logic [8:0]  trig;
  logic [11:0] paddr;
  logic [23:0] addr;
  logic [31:0] pwdata, prdata, rd;
  bebs_bus_t   bus;
  bebs_rec_t   rec;
  int          error_cnt = 0;
  int          compares = 0;

  bebs_sequencer uut (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .BUS_IN(bus), .TRACE_FULL_IN(tfull), .TRIG_IN(trig), .HALT_REQ_OUT(halt), .TRIG_OUT(tout),
    .TRACE_WE_OUT(twe), .TRACE_REC_OUT(rec), .ARMED_OUT(armed));
  bebs_core core (.clk_in(clk), .rst_in(rst), .go_in(go), .addr_in(addr), .halt_in(halt), .bus_out(bus),
    .halted_out());

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic results;
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // APB transfer; the wait for ready is bounded
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (pready !== 1'b1) begin
      chk(32'(pready), 32'h1);
      results();
    end
  endtask

  // One bus cycle; actions show one cycle after it is taken
  task automatic cyc(input logic [23:0] a);
    @(posedge clk);
    go   <= 1'b1;
    addr <= a;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic t_regs;
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'hFFC, 32'h1);
    chk(32'(er), 32'h1);
  endtask

  // Count of two on one address, then move to the second level
  task automatic t_count;
    apb(1'b1, 12'h100, 32'h123);
    apb(1'b1, 12'h10C, 32'h1);
    apb(1'b1, 12'h060, 32'h2);
    apb(1'b1, 12'h040, 32'hC241);
    apb(1'b1, 12'h000, 32'h1);
    cyc(24'h000123);
    chk(32'({tout, twe}), 32'h0);
    cyc(24'h000123);
    chk(32'(tout), 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk(32'(rd[2:1]), 32'h1);
  endtask

  // Alternative term: trigger line 3 AND trace full, trigger 1 toggles
  task automatic t_alt;
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h12C, 32'h1A00);
    apb(1'b1, 12'h13C, 32'h8000);
    apb(1'b1, 12'h044, 32'h405);
    trig <= 9'h008;
    apb(1'b1, 12'h000, 32'h9);
    cyc(24'h000055);
    chk(32'(tout), 32'h0);
    tfull <= 1'b1;
    cyc(24'h000055);
    chk(32'(tout), 32'h2);
    cyc(24'h000055);
    chk(32'(tout), 32'h0);
    trig <= 9'h000;
    cyc(24'h000055);
    chk(32'(tout), 32'h0);
    tfull <= 1'b0;
  endtask

  // Inclusive range with halt and snapshot after rearming
  task automatic t_halt;
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h100, 32'h200);
    apb(1'b1, 12'h104, 32'h20F);
    apb(1'b1, 12'h10C, 32'h3);
    apb(1'b1, 12'h040, 32'h2101);
    apb(1'b1, 12'h000, 32'h1);
    cyc(24'h000210);
    chk(32'(halt), 32'h0);
    cyc(24'h00020F);
    chk(32'({halt, twe, rec.snapshot}), 32'h7);
    chk(32'(rec.addr), 32'h20F);
    chk(32'(armed), 32'h1);
  endtask

  initial begin
    rst = 1'b1;
    {psel, pen, pwr, go, tfull} = '0;
    trig = '0;
    paddr = '0;
    pwdata = '0;
    addr = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_count();
    t_alt();
    t_halt();
    results();
  end
endmodule // tb_bus_event_breakpoint_sequencer
